// file: design/adcrw_params.svh
// Constants for the result word and clock select block
`ifndef ADCRW_PARAMS_SVH
`define ADCRW_PARAMS_SVH
`define ADCRW_WORD_BITS       32
`define ADCRW_EOC_BIT         31
`define ADCRW_CHAN_BIT        30
`define ADCRW_SIGN_BIT        29
`define ADCRW_MSB_BIT         28
`define ADCRW_LSB_BIT         5
`define ADCRW_SUB_BITS        5
`define ADCRW_RES_BITS        24
`define ADCRW_CODE_BITS       30
`define ADCRW_CODE_POS_CLAMP  30'h30000000
`define ADCRW_CODE_NEG_CLAMP  30'h0fffffff
`define ADCRW_CODE_POS_FS     30'h2fffffff
`define ADCRW_CODE_NEG_FS     30'h10000000
`define ADCRW_EXT_MIN_HZ      2560
`define ADCRW_NOTCH_DIV       2560
`define ADCRW_CLK_HZ          10000000
`define ADCRW_EXT_TIMEOUT     (`ADCRW_CLK_HZ / `ADCRW_EXT_MIN_HZ)
`define ADCRW_CONV_60_CYC     1330000
`define ADCRW_CONV_50_CYC     1600000
`define ADCRW_EXT_CONV_EDGES  20510
`endif

// file: design/adcrw_pkg.sv
// Types for the result word and clock select block
package adcrw_pkg;
	typedef enum logic [2:0] {
		ADCRW_CONVERT = 3'b001,
		ADCRW_SLEEP   = 3'b010,
		ADCRW_OUTPUT  = 3'b100
	} adcrw_state_t;

	typedef enum logic [2:0] {
		ADCRW_CLK_INT60 = 3'b001,
		ADCRW_CLK_INT50 = 3'b010,
		ADCRW_CLK_EXT   = 3'b100
	} adcrw_clksrc_t;

	typedef struct packed {
		logic        channel_flag;
		logic [29:0] code;
	} adcrw_result_t;
endpackage

// file: design/adcrw_fifo.sv
// Result FIFO between the modulator side and the serial word formatter
`timescale 1ns/10ps
module adcrw_fifo #(
	parameter int WIDTH = 31,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// file: design/adcrw_top.sv
// Result word formatter, serial shifter and conversion clock select
//
// Behaviour
// - Result word is 32 bits, MSB first
// - Three status, 24 result, five sub bits
// - Bit 31 is active-low conversion done flag
// - Bit 30 is channel: 0 or 1
// - Bit 29 high for positive input
// - Bits 29,28 flag over and underrange
// - Bits 28 to 5 hold the result
// - Bits 4 to 0 are sub-LSB bits
// - Chip select high: output off, clock ignored
// - Done flag falls live once select low
// - Bit 31 first, next bits on falls
// - Bit 0 on 31st falling edge
// - 32nd falling edge drives output high
// - Out of range clamps one LSB beyond
// - Select pin low 60 Hz, high 50 Hz
// - Notch change only spoils running conversion
// - Detect external clock, stop internal oscillator
// - External notch is clock over 2560
// - No external clock: back to internal
// - Source change keeps serial data valid
// - Channel 0 first, then alternate
// - Select high after first rise restarts
`timescale 1ns/10ps
`include "adcrw_params.svh"
module adcrw_top #(
	parameter int CONV_60_CYC = `ADCRW_CONV_60_CYC,
	parameter int CONV_50_CYC = `ADCRW_CONV_50_CYC,
	parameter int EXT_TIMEOUT = `ADCRW_EXT_TIMEOUT,
	parameter int EXT_EDGES   = `ADCRW_EXT_CONV_EDGES,
	parameter int FIFO_DEPTH  = 32
) (
	input  wire logic                  REF_CLK,
	input  wire logic                  SRST,
	input  wire logic                  CS_N,
	input  wire logic                  SCK,
	input  wire logic                  REJECTION_SELECT_PIN,
	input  wire logic [31:0]           MOD_SAMPLE,
	output logic                       SDO_O,
	output logic                       SDO_OE,
	output logic                       EXT_CLK_ACTIVE,
	output logic                       INT_OSC_EN,
	output adcrw_pkg::adcrw_clksrc_t   CLK_SOURCE,
	output adcrw_pkg::adcrw_state_t    STATE
);
	import adcrw_pkg::*;

	localparam int TW = $clog2(CONV_50_CYC + EXT_EDGES + 1) + 1;
	localparam int EW = $clog2(EXT_TIMEOUT + 1) + 1;

	// Two-flop synchronisers for the CS_N, SCK and rejection select pins
	logic [1:0] cs_sync_reg;
	logic [1:0] sck_sync_reg;
	logic [1:0] f0_sync_reg;
	logic       cs_n;
	logic       sck;
	logic       f0;
	logic       sck_d_reg;
	logic       f0_d_reg;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			cs_sync_reg  <= 2'h3;
			sck_sync_reg <= 2'h0;
			f0_sync_reg  <= 2'h0;
			sck_d_reg    <= 1'b0;
			f0_d_reg     <= 1'b0;
		end else begin
			cs_sync_reg  <= {cs_sync_reg[0], CS_N};
			sck_sync_reg <= {sck_sync_reg[0], SCK};
			f0_sync_reg  <= {f0_sync_reg[0], REJECTION_SELECT_PIN};
			sck_d_reg    <= sck_sync_reg[1];
			f0_d_reg     <= f0_sync_reg[1];
		end
	end

	assign cs_n = cs_sync_reg[1];
	assign sck  = sck_sync_reg[1];
	assign f0   = f0_sync_reg[1];

	logic sck_rise;
	logic sck_fall;
	logic f0_edge;
	assign sck_rise = sck && !sck_d_reg;
	assign sck_fall = !sck && sck_d_reg;
	assign f0_edge  = f0 && !f0_d_reg;

	// Clock source: a rising edge within the timeout marks an external clock
	logic [EW-1:0] ext_gap_reg;
	logic          ext_reg;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			// Start saturated: a lone edge after reset is no external clock
			ext_gap_reg <= EW'(EXT_TIMEOUT);
			ext_reg     <= 1'b0;
		end else if (f0_edge) begin
			ext_gap_reg <= '0;
			ext_reg     <= ext_gap_reg < EW'(EXT_TIMEOUT);
		end else if (ext_gap_reg < EW'(EXT_TIMEOUT)) begin
			ext_gap_reg <= ext_gap_reg + 1'b1;
		end else begin
			ext_reg <= 1'b0;
		end
	end

	adcrw_clksrc_t clksrc_next;
	always_comb begin
		if (ext_reg) begin
			clksrc_next = ADCRW_CLK_EXT;
		end else if (f0) begin
			clksrc_next = ADCRW_CLK_INT50;
		end else begin
			clksrc_next = ADCRW_CLK_INT60;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			CLK_SOURCE     <= ADCRW_CLK_INT60;
			EXT_CLK_ACTIVE <= 1'b0;
			INT_OSC_EN     <= 1'b1;
		end else begin
			CLK_SOURCE     <= clksrc_next;
			EXT_CLK_ACTIVE <= ext_reg;
			// internal oscillator stopped on external clock
			INT_OSC_EN     <= !ext_reg;
		end
	end

	// Result path: clamp and encode, then queue in the FIFO
	logic          chan_reg;
	adcrw_result_t res_in;
	adcrw_result_t res_out;
	logic          fifo_in_ready;
	logic          fifo_out_valid;
	logic          fifo_pop;
	logic          conv_done;
	logic signed [31:0] s;

	assign s = MOD_SAMPLE;

	always_comb begin
		res_in.channel_flag = chan_reg;
		// clamp one LSB beyond full scale
		if (s > $signed({2'h0, `ADCRW_CODE_POS_FS}) - 32'sh20000000) begin
			res_in.code = `ADCRW_CODE_POS_CLAMP;
		end else if (s < -32'sh10000000) begin
			res_in.code = `ADCRW_CODE_NEG_CLAMP;
		end else begin
			// offset binary: sign set for zero and up
			res_in.code = s[29:0] + `ADCRW_CODE_NEG_FS + `ADCRW_CODE_NEG_FS;
		end
	end

	adcrw_fifo #(
		.WIDTH($bits(adcrw_result_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk      (REF_CLK),
		.srst     (SRST),
		.in_data  (res_in),
		.in_valid (conv_done),
		.in_ready (fifo_in_ready),
		.out_data (res_out),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop)
	);

	// Conversion, sleep and output states
	adcrw_state_t  state_reg;
	adcrw_state_t  state_next;
	logic [TW-1:0] conv_cnt_reg;
	logic [TW-1:0] conv_len;
	logic [5:0]    bit_cnt_reg;
	logic          risen_reg;
	logic [31:0]   shift_reg;
	logic          end_out;

	// external mode counts clock edges, notch follows that clock
	assign conv_len = (CLK_SOURCE == ADCRW_CLK_EXT) ? TW'(EXT_EDGES) :
		(CLK_SOURCE == ADCRW_CLK_INT50) ? TW'(CONV_50_CYC) : TW'(CONV_60_CYC);
	// A full result only enters the FIFO when there is room, stalling conversion
	assign conv_done = (state_reg == ADCRW_CONVERT) && (conv_cnt_reg >= conv_len);
	assign fifo_pop  = (state_reg == ADCRW_SLEEP) && fifo_out_valid && !cs_n;
	// select high after a first rise; 32 bits done
	assign end_out   = (state_reg == ADCRW_OUTPUT) &&
		((cs_n && risen_reg) || (sck_fall && bit_cnt_reg == 6'd31));

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ADCRW_CONVERT: begin
				if (conv_done && fifo_in_ready) begin
					state_next = ADCRW_SLEEP;
				end
			end
			ADCRW_SLEEP: begin
				if (fifo_pop) begin
					state_next = ADCRW_OUTPUT;
				end
			end
			ADCRW_OUTPUT: begin
				if (end_out) begin
					state_next = ADCRW_CONVERT;
				end
			end
			default: begin
				state_next = ADCRW_CONVERT;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			state_reg <= ADCRW_CONVERT;
		end else begin
			state_reg <= state_next;
		end
	end

	// a source change keeps the running count and only moves its end
	always_ff @(posedge REF_CLK) begin
		if (SRST || state_reg != ADCRW_CONVERT) begin
			conv_cnt_reg <= '0;
		end else if (conv_cnt_reg < conv_len) begin
			if (CLK_SOURCE != ADCRW_CLK_EXT || f0_edge) begin
				conv_cnt_reg <= conv_cnt_reg + 1'b1;
			end
		end
	end

	// channel 0 first, alternate per conversion
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			chan_reg <= 1'b0;
		end else if (conv_done && fifo_in_ready) begin
			chan_reg <= !chan_reg;
		end
	end

	// shifting only while select is low
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			shift_reg   <= '1;
			bit_cnt_reg <= '0;
			risen_reg   <= 1'b0;
		end else if (fifo_pop) begin
			shift_reg   <= {1'b0, res_out.channel_flag, res_out.code};
			bit_cnt_reg <= '0;
			risen_reg   <= 1'b0;
		end else if (state_reg == ADCRW_OUTPUT && !cs_n) begin
			if (sck_rise) begin
				risen_reg <= 1'b1;
			end
			// one bit per falling edge, MSB first
			if (sck_fall && risen_reg) begin
				shift_reg   <= {shift_reg[30:0], 1'b1};
				bit_cnt_reg <= bit_cnt_reg + 1'b1;
			end
		end
	end

	// flag high in conversion, low in sleep, bit 31 low in output state
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			SDO_O  <= 1'b1;
			SDO_OE <= 1'b0;
			STATE  <= ADCRW_CONVERT;
		end else begin
			SDO_OE <= !cs_n;
			STATE  <= state_next;
			if (state_next == ADCRW_OUTPUT) begin
				SDO_O <= (fifo_pop) ? 1'b0 : shift_reg[31];
				if (sck_fall && risen_reg && !fifo_pop) begin
					SDO_O <= shift_reg[30];
				end
			end else begin
				SDO_O <= (state_next == ADCRW_SLEEP) ? 1'b0 : 1'b1;
			end
		end
	end

	// Sleep with select low pulls the result out at once, so sleep output is low
	// overrange reads sign and MSB both high
	ovr_flag_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(conv_done && s > 32'sh10000000) |-> res_in.code[29:28] == 2'b11)
		else $error("overrange code wrong");
	udr_flag_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(conv_done && s < -32'sh10000000) |-> res_in.code[29:28] == 2'b00)
		else $error("underrange code wrong");
	zero_code_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(s == 32'sh0) |-> res_in.code == 30'h20000000)
		else $error("zero code wrong");
	sign_bit_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(s == -32'sh1) |-> res_in.code == 30'h1fffffff)
		else $error("minus one code wrong");
	hiz_cs_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		$past(cs_n) |-> !SDO_OE)
		else $error("output driven while deselected");
	chan_alt_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(conv_done && fifo_in_ready) |=> chan_reg != $past(chan_reg))
		else $error("channel did not alternate");
	word_end_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(end_out && !cs_n) |=> SDO_O && state_reg == ADCRW_CONVERT)
		else $error("output not high after word");
	first_bit_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(fifo_pop && !cs_n) |=> !SDO_O ##1 (state_reg == ADCRW_OUTPUT))
		else $error("done flag not low on output");
	osc_stop_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		ext_reg |=> !INT_OSC_EN)
		else $error("oscillator running with external clock");
	conv_flag_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(STATE == ADCRW_CONVERT) |-> SDO_O)
		else $error("done flag low during conversion");
	sleep_flag_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(STATE == ADCRW_SLEEP) |-> !SDO_O)
		else $error("done flag high in sleep");
	notch_60_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(!ext_reg && !f0) |=> CLK_SOURCE == ADCRW_CLK_INT60)
		else $error("60 Hz notch not selected");
	notch_50_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(!ext_reg && f0) |=> CLK_SOURCE == ADCRW_CLK_INT50)
		else $error("50 Hz notch not selected");
	ext_src_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		ext_reg |=> CLK_SOURCE == ADCRW_CLK_EXT)
		else $error("external source not selected");
	ext_count_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(state_reg == ADCRW_CONVERT && CLK_SOURCE == ADCRW_CLK_EXT && !f0_edge &&
		!conv_done) |=> $stable(conv_cnt_reg))
		else $error("conversion counted without external edge");
	ext_lost_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(ext_gap_reg == EW'(EXT_TIMEOUT) && !f0_edge) |=> !ext_reg)
		else $error("external clock kept after timeout");
	osc_run_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		!ext_reg |=> INT_OSC_EN)
		else $error("oscillator off without external clock");
	shift_hold_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		cs_n |=> $stable(shift_reg))
		else $error("word moved while deselected");
	bit_step_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(state_reg == ADCRW_OUTPUT && !cs_n && sck_fall && risen_reg) |=>
		(shift_reg[31:1] == $past(shift_reg[30:0]) && SDO_O == shift_reg[31]))
		else $error("bit step wrong");
	word_len_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		bit_cnt_reg <= 6'd32)
		else $error("more than 32 bits shifted");
	// select high after rise ends output
	abort_end_a: assert property (@(posedge REF_CLK) disable iff (SRST)
		(state_reg == ADCRW_OUTPUT && cs_n && risen_reg) |=> state_reg == ADCRW_CONVERT)
		else $error("abort did not restart conversion");
endmodule

// file: test/adcrw_host.sv
// Host serial port model that reads result words from the converter
`timescale 1ns/10ps
module adcrw_host (
	input  wire logic clk,
	input  wire logic sdo,
	input  wire logic sdo_oe,
	output logic      cs_n,
	output logic      sck
);
	logic last_reg;
	logic line;
	logic tail;

	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		last_reg = 1'b0;
		tail = 1'b0;
	end

	always @(posedge clk) begin
		if (sdo_oe)
			last_reg <= sdo;
	end
	// A released line shows the inverse of the last driven level
	assign line = sdo_oe ? sdo : ~last_reg;

	// Each level is held well past the device's input synchronizer
	task automatic half();
		repeat (6) @(negedge clk);
	endtask

	// Pulses with select high must not move the word
	task automatic noise();
		repeat (3) begin
			sck = 1'b1;
			half();
			sck = 1'b0;
			half();
		end
	endtask

	// select low, then wait for done flag
	task automatic select(output int cyc);
		cs_n = 1'b0;
		cyc = 0;
		while ((sdo_oe !== 1'b1 || line !== 1'b0) && cyc < 2000) begin
			@(negedge clk);
			cyc++;
		end
	endtask

	// capture before each rise, device shifts on falls
	task automatic shift(input int nbits, output logic [31:0] w);
		w = '0;
		for (int i = 0; i < nbits; i++) begin
			w[31-i] = line;
			sck = 1'b1;
			half();
			sck = 1'b0;
			half();
		end
		tail = line;
		cs_n = 1'b1;
		half();
	endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the result word and clock select block
`timescale 1ns/10ps
module testbench;
	import adcrw_pkg::*;
	localparam int C60 = 50;
	localparam int C50 = 60;
	localparam int EXT_N = 8;
	// Period of the external conversion clock in reference cycles
	localparam int EXT_PER = 20;
	logic                 ref_clk;
	logic                 srst;
	logic                 rsel;
	logic                 ext_run;
	logic signed [31:0]   sample;
	logic                 cs_n;
	logic                 sck;
	logic                 sdo_o;
	logic                 sdo_oe;
	logic                 ext_active;
	logic                 osc_en;
	adcrw_clksrc_t        clk_src;
	adcrw_state_t         state;
	int                   num_errors;
	int                   checks;
	logic signed [31:0]   tbl [7] = '{32'sh0, -32'sh1, 32'sh0fffffff, -32'sh10000000,
		32'sh10000000, -32'sh10000001, 32'sh7fffffff};

	adcrw_top #(.CONV_60_CYC(C60), .CONV_50_CYC(C50), .EXT_TIMEOUT(40), .EXT_EDGES(EXT_N),
		.FIFO_DEPTH(32)) adcrw_top_i (
		.REF_CLK(ref_clk), .SRST(srst), .CS_N(cs_n), .SCK(sck),
		.REJECTION_SELECT_PIN(rsel), .MOD_SAMPLE(sample), .SDO_O(sdo_o),
		.SDO_OE(sdo_oe), .EXT_CLK_ACTIVE(ext_active), .INT_OSC_EN(osc_en),
		.CLK_SOURCE(clk_src), .STATE(state));

	adcrw_host adcrw_host_i (.clk(ref_clk), .sdo(sdo_o), .sdo_oe(sdo_oe), .cs_n(cs_n),
		.sck(sck));

	always #50 ref_clk = ~ref_clk;
	// External conversion clock, 20 cycles a period
	always #1000 if (ext_run) rsel = ~rsel;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic do_reset();
		srst = 1'b1;
		repeat (5) @(negedge ref_clk);
		srst = 1'b0;
	endtask

	function automatic logic [29:0] exp_code(input logic signed [31:0] s);
		if (s > 32'sh0fffffff)
			return 30'h30000000;
		if (s < -32'sh10000000)
			return 30'h0fffffff;
		return 30'(s + 32'sh20000000);
	endfunction

	task automatic read_expect(input logic ch);
		int          cyc;
		logic [31:0] w;
		adcrw_host_i.noise();
		check({31'h0, sdo_oe}, 32'h0);
		adcrw_host_i.select(cyc);
		adcrw_host_i.shift(32, w);
		check(w, {1'b0, ch, exp_code(sample)});
		check({31'h0, adcrw_host_i.tail}, 32'h1);
	endtask

	task automatic notch(input logic lvl, input int conv, input adcrw_clksrc_t src);
		int          cyc;
		logic [31:0] w;
		rsel = lvl;
		do_reset();
		adcrw_host_i.select(cyc);
		check({31'h0, cyc >= conv && cyc < conv + 12}, 32'h1);
		check(32'(clk_src), 32'(src));
		adcrw_host_i.shift(32, w);
		check(w, {2'b00, exp_code(sample)});
	endtask

	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		rsel = 1'b0;
		ext_run = 1'b0;
		sample = '0;
		num_errors = 0;
		checks = 0;
		foreach (tbl[i]) begin
			sample = tbl[i];
			do_reset();
			read_expect(1'b0);
			read_expect(1'b1);
		end
		$display("test format done");
		sample = 32'sh00001234;
		notch(1'b0, C60, ADCRW_CLK_INT60);
		notch(1'b1, C50, ADCRW_CLK_INT50);
		$display("test notch done");
		begin
			int          cyc;
			logic [31:0] w;
			do_reset();
			adcrw_host_i.select(cyc);
			// Select dropped before any rise keeps the word
			adcrw_host_i.shift(0, w);
			adcrw_host_i.select(cyc);
			check({31'h0, cyc < 12}, 32'h1);
			adcrw_host_i.shift(2, w);
			check(w, 32'h0);
			check(32'(state), 32'(ADCRW_CONVERT));
			read_expect(1'b1);
		end
		$display("test abort done");
		do_reset();
		// Long idle: the finished result waits in sleep and none is lost
		repeat (40 * C50) @(negedge ref_clk);
		for (int i = 0; i < 33; i++)
			read_expect(1'(i));
		$display("test buffer done");
		do_reset();
		ext_run = 1'b1;
		repeat (100) @(negedge ref_clk);
		check({30'h0, ext_active, osc_en}, 32'h2);
		check(32'(clk_src), 32'(ADCRW_CLK_EXT));
		read_expect(1'b0);
		begin
			int          cyc;
			logic [31:0] w;
			// A whole conversion on the external clock takes EXT_N of its periods
			adcrw_host_i.select(cyc);
			check({31'h0, cyc > (EXT_N - 2) * EXT_PER}, 32'h1);
			check({31'h0, cyc < (EXT_N + 1) * EXT_PER}, 32'h1);
			adcrw_host_i.shift(32, w);
			check(w, {2'b01, exp_code(sample)});
		end
		ext_run = 1'b0;
		repeat (100) @(negedge ref_clk);
		check({30'h0, ext_active, osc_en}, 32'h1);
		check(32'(clk_src), 32'(rsel ? ADCRW_CLK_INT50 : ADCRW_CLK_INT60));
		read_expect(1'b0);
		$display("test ext clock done");
		summarize();
	end

	initial begin
		#4000000;
		num_errors++;
		summarize();
	end
endmodule
